/* File: design/gate_status_pkg.sv */
`default_nettype none
package gate_status_pkg;
  // -------------------------------------------------------------
  // register map, 7-bit addresses as carried by the serial frame
  // -------------------------------------------------------------
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam logic [6:0] OV_FLAGS_ADDR = 7'h52;
  localparam logic [6:0] HB1_DELAYS_ADDR = 7'h53;
  localparam logic [6:0] HB2_DELAYS_ADDR = 7'h54;
  localparam logic [6:0] HB3_DELAYS_ADDR = 7'h55;
  localparam logic [6:0] HB1_EDGES_ADDR = 7'h57;

  // -------------------------------------------------------------
  // overvoltage flag positions
  // -------------------------------------------------------------
  localparam int OV_FLAG_COUNT = 5;
  localparam int HIGH1_OV_BIT = 0;
  localparam int LOW1_OV_BIT = 1;
  localparam int HIGH2_OV_BIT = 2;
  localparam int LOW2_OV_BIT = 3;
  localparam int HIGH3_OV_BIT = 4;

  // -------------------------------------------------------------
  // timing field layout and scale
  // -------------------------------------------------------------
  localparam int FIELD_W = 6;
  localparam int LOW_FIELD_LSB = 0;
  localparam int HIGH_FIELD_LSB = 8;
  localparam real TIMING_STEP_NS = 53.3;
  localparam int TIMING_SLOTS = 4;
  localparam int HB1_EDGE_SLOT = 3;

  // -------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------
  localparam logic [15:0] OV_FLAGS_RESET = 16'h0000;
  localparam logic [5:0] FIELD_RESET = 6'h00;
  localparam logic [15:0] UNMAPPED_READ = 16'h0000;
endpackage
`default_nettype wire

/* File: design/timing_meas_if.sv */
`default_nettype none
interface timing_meas_if;
  logic strobe;
  logic [5:0] lowField;
  logic [5:0] highField;
  logic [15:0] word;
  modport src (output strobe, output lowField, output highField,
               input word);
  modport sink (input strobe, input lowField, input highField,
                output word);
endinterface
`default_nettype wire

/* File: design/timing_capture.sv */
`default_nettype none
module timing_capture (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // measurement in, register word out
  timing_meas_if.sink meas
);
  logic [5:0] low_q;
  logic [5:0] low_d;
  logic [5:0] high_q;
  logic [5:0] high_d;

  // a new measurement replaces the old pair as one, never half of it
  assign low_d = meas.strobe ? meas.lowField : low_q;
  assign high_d = meas.strobe ? meas.highField : high_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      low_q <= gate_status_pkg::FIELD_RESET;
      high_q <= gate_status_pkg::FIELD_RESET;
    end else begin
      low_q <= low_d;
      high_q <= high_d;
    end
  end

  // reserved 15:14 and 7:6 are tied low
  assign meas.word = {2'h0, high_q, 2'h0, low_q};
endmodule // timing_capture
`default_nettype wire

/* File: design/gate_driver_status_regs.sv */
// Functional notes
// - high-side flags at bits 0, 2, 4 set on overvoltage, clear on read
// - low-side overvoltage flags at bits 1 and 3 set on event, clear on read
// - flags reset to zero; restart keeps them, bits 15, 11, 7, 6 zero
// - half-bridge one turn-off delay in bits 13:8, 53.3 ns steps
// - half-bridge one turn-on delay in bits 5:0, 53.3 ns steps
// - half-bridges two and three have same delay layout in own registers
// - reserved bits always read zero
// - half-bridge one fall time in bits 13:8, 53.3 ns steps
// - half-bridge one rise time in bits 5:0, 53.3 ns steps
`default_nettype none
module gate_driver_status_regs (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register read port from the serial frame decoder
  input wire logic rdEn,
  input wire logic [6:0] rdAddr,
  output logic [15:0] rdData,
  output logic rdValid,
  output logic rdMapped,
  // overvoltage detector pulses, one per switch except the low side of half-bridge three
  input wire logic high1_ov_flag_evt,
  input wire logic low1_ov_flag_evt,
  input wire logic high2_ov_flag_evt,
  input wire logic low2_ov_flag_evt,
  input wire logic high3_ov_flag_evt,
  // effective delay measurements, index 0 is half-bridge one
  input wire logic [2:0] delayStrobe,
  input wire logic [2:0][5:0] bridgeOnDelay,
  input wire logic [2:0][5:0] bridgeOffDelay,
  // half-bridge one edge time measurement
  input wire logic edgeStrobe,
  input wire logic [5:0] bridge1_rise_time,
  input wire logic [5:0] bridge1_fall_time,
  // live flag view for the protection logic
  output logic [4:0] ovFlags
);
  // -------------------------------------------------------------
  // read decode
  // -------------------------------------------------------------
  wire hitOv;
  wire hitHb1;
  wire hitHb2;
  wire hitHb3;
  wire hitEdge;
  wire hitAny;
  wire readOv;
  wire [4:0] laneHit;
  genvar gi;

  // lane 0 is the flag register, then the timing registers in order
  localparam logic [4:0][6:0] LANE_ADDR = {
    gate_status_pkg::HB1_EDGES_ADDR,
    gate_status_pkg::HB3_DELAYS_ADDR,
    gate_status_pkg::HB2_DELAYS_ADDR,
    gate_status_pkg::HB1_DELAYS_ADDR,
    gate_status_pkg::OV_FLAGS_ADDR
  };

  generate
    for (gi = 0; gi < 5; gi++) begin : g_hit
      assign laneHit[gi] = rdAddr == LANE_ADDR[gi];
    end
  endgenerate

  assign hitOv = laneHit[0];
  assign hitHb1 = laneHit[1];
  assign hitHb2 = laneHit[2];
  assign hitHb3 = laneHit[3];
  assign hitEdge = laneHit[4];
  // an unmapped address hits no lane and reads as the idle word
  assign hitAny = hitOv | hitHb1 | hitHb2 | hitHb3 | hitEdge;
  assign readOv = rdEn & hitOv;

  // -------------------------------------------------------------
  // overvoltage flags
  // -------------------------------------------------------------
  logic [4:0] ovEvt;
  logic [4:0] ov_q;
  logic [4:0] ov_d;
  logic [4:0] ovKeep;

  assign ovEvt[gate_status_pkg::HIGH1_OV_BIT] = high1_ov_flag_evt;
  assign ovEvt[gate_status_pkg::HIGH2_OV_BIT] = high2_ov_flag_evt;
  assign ovEvt[gate_status_pkg::HIGH3_OV_BIT] = high3_ov_flag_evt;
  assign ovEvt[gate_status_pkg::LOW1_OV_BIT] = low1_ov_flag_evt;
  assign ovEvt[gate_status_pkg::LOW2_OV_BIT] = low2_ov_flag_evt;

  // the read captures the old value on the same edge that clears it,
  // and an event in that cycle wins, so nothing is ever lost
  generate
    for (gi = 0; gi < gate_status_pkg::OV_FLAG_COUNT; gi++) begin : g_ov
      assign ovKeep[gi] = ov_q[gi] & ~readOv;
      assign ov_d[gi] = ovEvt[gi] | ovKeep[gi];
    end
  endgenerate

  // a restart is not a reset here: flags simply survive it, which
  // matches the undefined restart bits; the forced bits do not exist
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ov_q <= gate_status_pkg::OV_FLAGS_RESET[4:0];
    end else begin
      ov_q <= ov_d;
    end
  end

  assign ovFlags = ov_q;

  // -------------------------------------------------------------
  // timing capture slots
  // -------------------------------------------------------------
  timing_meas_if measBus [gate_status_pkg::TIMING_SLOTS] ();
  logic [3:0][15:0] slotWord;

  generate
    for (gi = 0; gi < 3; gi++) begin : g_delay
      assign measBus[gi].strobe = delayStrobe[gi];
      assign measBus[gi].lowField = bridgeOnDelay[gi];
      assign measBus[gi].highField = bridgeOffDelay[gi];
      assign slotWord[gi] = measBus[gi].word;
    end
  endgenerate

  assign measBus[gate_status_pkg::HB1_EDGE_SLOT].strobe = edgeStrobe;
  assign measBus[gate_status_pkg::HB1_EDGE_SLOT].lowField =
    bridge1_rise_time;
  assign measBus[gate_status_pkg::HB1_EDGE_SLOT].highField =
    bridge1_fall_time;
  assign slotWord[gate_status_pkg::HB1_EDGE_SLOT] =
    measBus[gate_status_pkg::HB1_EDGE_SLOT].word;

  generate
    for (gi = 0; gi < gate_status_pkg::TIMING_SLOTS; gi++) begin : g_cap
      timing_capture u_cap (
        .clk_sys(clk_sys),
        .rst(rst),
        .meas(measBus[gi])
      );
    end
  endgenerate

  // -------------------------------------------------------------
  // read source lanes
  // -------------------------------------------------------------
  wire [15:0] ovWord;
  wire [15:0] readMux;
  wire [4:0][15:0] laneWord;
  wire [4:0][15:0] laneMasked;
  wire [5:0][15:0] laneOr;

  // bits 15:5 of the flag register read zero
  assign ovWord[15:gate_status_pkg::OV_FLAG_COUNT] = 11'h000;
  generate
    for (gi = 0; gi < gate_status_pkg::OV_FLAG_COUNT; gi++) begin : g_ovw
      assign ovWord[gi] = ov_q[gi];
    end
  endgenerate

  // an and-or chain folds the lanes in one after another, lane 0 deepest; lanes cannot
  // overlap because every address in the table is distinct
  assign laneWord[0] = ovWord;
  assign laneWord[1] = slotWord[0];
  assign laneWord[2] = slotWord[1];
  assign laneWord[3] = slotWord[2];
  assign laneWord[4] = slotWord[gate_status_pkg::HB1_EDGE_SLOT];
  // unmapped addresses answer the idle word so a stray read is harmless
  assign laneOr[0] =
    hitAny ? 16'h0000 : gate_status_pkg::UNMAPPED_READ;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_lane
      assign laneMasked[gi] = laneWord[gi] & {16{laneHit[gi]}};
      assign laneOr[gi + 1] = laneOr[gi] | laneMasked[gi];
    end
  endgenerate

  assign readMux = laneOr[5];

  // -------------------------------------------------------------
  // answer register
  // -------------------------------------------------------------
  logic [15:0] rdData_q;
  logic [15:0] rdData_d;
  logic rdValid_q;
  logic rdMapped_q;
  logic rdMapped_d;

  // the answer holds between reads so a slow host can fetch it late
  assign rdData_d = rdEn ? readMux : rdData_q;
  assign rdMapped_d = rdEn ? hitAny : rdMapped_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdData_q <= 16'h0000;
    end else begin
      rdData_q <= rdData_d;
    end
  end

  // the only handshake output; it repeats rdEn one cycle later, high for as many cycles as rdEn was
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdValid_q <= 1'b0;
    end else begin
      rdValid_q <= rdEn;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdMapped_q <= 1'b0;
    end else begin
      rdMapped_q <= rdMapped_d;
    end
  end

  assign rdData = rdData_q;
  assign rdValid = rdValid_q;
  assign rdMapped = rdMapped_q;
endmodule // gate_driver_status_regs
`default_nettype wire

/* File: tb/gate_status_asserts.sv */
`default_nettype none
module gate_status_asserts (
  // watched top ports
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic rdEn,
  input wire logic [6:0] rdAddr,
  input wire logic [15:0] rdData,
  input wire logic rdValid,
  input wire logic high1_ov_flag_evt,
  input wire logic low1_ov_flag_evt,
  input wire logic [2:0] delayStrobe,
  input wire logic [2:0][5:0] bridgeOnDelay,
  input wire logic [2:0][5:0] bridgeOffDelay,
  input wire logic edgeStrobe,
  input wire logic [5:0] bridge1_rise_time,
  input wire logic [5:0] bridge1_fall_time,
  input wire logic [4:0] ovFlags
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire logic ovRd = rdEn && rdAddr == gate_status_pkg::OV_FLAGS_ADDR;
  a_high_flag_set: assert property (high1_ov_flag_evt |=> ovFlags[0])
    else $error("high flag not set");
  a_low_flag_set: assert property (low1_ov_flag_evt |=> ovFlags[1])
    else $error("low flag not set");
  a_read_clears: assert property (
    ovRd && !high1_ov_flag_evt |=> !ovFlags[0]) else $error("not cleared");
  a_read_returns: assert property (
    ovRd |=> rdValid && rdData[4:0] == $past(ovFlags))
    else $error("flags read wrong");
  a_reserved_zero: assert property (
    rdValid |-> rdData[15:14] == 2'h0 && rdData[7:6] == 2'h0)
    else $error("reserved bits set");
  a_ov_upper_zero: assert property (ovRd |=> rdData[15:5] == 11'h000)
    else $error("upper flag bits set");
  a_hb1_delay_word: assert property (
    delayStrobe[0] ##1 (rdEn && rdAddr == gate_status_pkg::HB1_DELAYS_ADDR)
    |=> rdData == {2'h0, $past(bridgeOffDelay[0], 2), 2'h0,
    $past(bridgeOnDelay[0], 2)}) else $error("delay word wrong");
  a_edge_time_word: assert property (
    edgeStrobe ##1 (rdEn && rdAddr == gate_status_pkg::HB1_EDGES_ADDR)
    |=> rdData == {2'h0, $past(bridge1_fall_time, 2), 2'h0,
    $past(bridge1_rise_time, 2)}) else $error("edge word wrong");
  c_flag_read: cover property (ovRd ##1 rdData[4:0] != 5'h00);
  c_delay_read: cover property (delayStrobe[0] ##1 rdEn);
  c_edge_read: cover property (edgeStrobe ##1 rdEn);
endmodule // gate_status_asserts
bind gate_driver_status_regs gate_status_asserts u_gate_status_asserts (
  .clk_sys, .rst, .rdEn, .rdAddr, .rdData, .rdValid, .high1_ov_flag_evt,
  .low1_ov_flag_evt, .delayStrobe, .bridgeOnDelay, .bridgeOffDelay,
  .edgeStrobe, .bridge1_rise_time, .bridge1_fall_time, .ovFlags);
`default_nettype wire

/* File: tb/host_reader.sv */
`default_nettype none
module host_reader (
  // clock
  input wire logic clk_sys,
  // read request
  output logic rdEn,
  output logic [6:0] rdAddr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rdEn = 1'b0;
    rdAddr = 7'h00;
  end
  // called just after an edge; idle cycle keeps rdEn writes apart
  task automatic rd(input logic [6:0] a);
    rdEn <= 1'b1;
    rdAddr <= a;
    @(posedge clk_sys);
    rdEn <= 1'b0;
    rdAddr <= ~a;
    @(posedge clk_sys);
  endtask
endmodule // host_reader
`default_nettype wire

/* File: tb/gate_driver_status_regs_tb.sv */
`default_nettype none
module gate_driver_status_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst, edgeStrobe, rdEn, rdValid, rdMapped;
  logic [6:0] rdAddr;
  logic [15:0] rdData;
  logic [4:0] evt, ovFlags;
  logic [2:0] delayStrobe;
  logic [2:0][5:0] onD, offD;
  logic [5:0] rise, fall;
  logic [31:0] seed = 32'h2C3C1101;
  logic [16:0] expQ[$];
  logic [16:0] got;
  int error_cnt = 0;
  int cmp_count = 0;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  host_reader u_host_reader (.clk_sys, .rdEn, .rdAddr);
  gate_driver_status_regs u_gate_driver_status_regs (
    .clk_sys, .rst, .rdEn, .rdAddr, .rdData, .rdValid, .rdMapped,
    .high1_ov_flag_evt(evt[0]), .low1_ov_flag_evt(evt[1]),
    .high2_ov_flag_evt(evt[2]), .low2_ov_flag_evt(evt[3]),
    .high3_ov_flag_evt(evt[4]), .delayStrobe, .bridgeOnDelay(onD),
    .bridgeOffDelay(offD), .edgeStrobe, .bridge1_rise_time(rise),
    .bridge1_fall_time(fall), .ovFlags);
  task automatic chk(input logic [6:0] a, input logic [16:0] e);
    expQ.push_back(e);
    u_host_reader.rd(a);
  endtask
  task automatic wrap_up;
    if (error_cnt == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // sampled off the edge so registered outputs have settled
  always @(negedge clk_sys) begin
    if (rdValid === 1'b1 && expQ.size() == 0) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time,
        {rdMapped, rdData}, 17'h00000);
    end else if (rdValid === 1'b1) begin
      got = expQ.pop_front();
      cmp_count++;
      if ({rdMapped, rdData} !== got) begin
        error_cnt++;
        $display("wrong value at %0t: got %h expected %h", $time,
          {rdMapped, rdData}, got);
      end
    end
  end
  initial begin
    rst = 1'b1;
    evt = 5'h00;
    delayStrobe = 3'h0;
    edgeStrobe = 1'b0;
    onD = '0;
    offD = '0;
    rise = 6'h00;
    fall = 6'h00;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      chk(7'h52 + 7'(i), {i != 4, 16'h0000});
    end
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      onD[i] <= seed[5:0];
      offD[i] <= seed[13:8];
      delayStrobe <= 3'h1 << i;
      @(posedge clk_sys);
      delayStrobe <= 3'h0;
      chk(7'h53 + 7'(i), {3'h4, seed[13:8], 2'h0, seed[5:0]});
    end
    seed = xs(seed);
    rise <= seed[5:0];
    fall <= seed[21:16];
    edgeStrobe <= 1'b1;
    @(posedge clk_sys);
    edgeStrobe <= 1'b0;
    chk(7'h57, {3'h4, seed[21:16], 2'h0, seed[5:0]});
    for (int k = 0; k < 5; k++) begin
      evt <= 5'h01 << k;
      @(posedge clk_sys);
      evt <= 5'h00;
      chk(7'h56, 17'h00000);
      chk(7'h52, {12'h800, 5'h01 << k});
      chk(7'h52, 17'h10000);
    end
    evt <= 5'h1F;
    @(posedge clk_sys);
    chk(7'h52, 17'h1001F);
    evt <= 5'h00;
    chk(7'h52, 17'h1001F);
    chk(7'h52, 17'h10000);
    evt <= 5'h1F;
    delayStrobe <= 3'h7;
    edgeStrobe <= 1'b1;
    @(posedge clk_sys);
    evt <= 5'h00;
    delayStrobe <= 3'h0;
    edgeStrobe <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    chk(7'h52, 17'h10000);
    chk(7'h53, 17'h10000);
    chk(7'h57, 17'h10000);
    repeat (4) @(posedge clk_sys);
    if (expQ.size() != 0) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time,
        expQ.size(), 0);
    end
    wrap_up();
  end
  initial begin
    #20us;
    error_cnt++;
    wrap_up();
  end
endmodule // gate_driver_status_regs_tb
`default_nettype wire
